// ---- rtl/pasb_params.svh ----
// constants for the periodic sample buffer: register offsets, field positions,
// reset values and channel encodings
// assumes: included by bare name wherever the block's numbers are needed
`ifndef PASB_PARAMS_SVH
`define PASB_PARAMS_SVH

// register byte offsets on the 12-bit lite bus address
`define PASB_OFF_CTRL     12'h000
`define PASB_OFF_STATUS   12'h004
`define PASB_OFF_CHMASK   12'h008
`define PASB_OFF_PERIOD   12'h00c
`define PASB_OFF_BUFLEN   12'h010
`define PASB_OFF_ITERS    12'h014
`define PASB_OFF_INDEX    12'h018
`define PASB_OFF_IRQSTAT  12'h01c
`define PASB_OFF_IRQMASK  12'h020
// sample buffer window, one word per location, read only
`define PASB_BUF_REGION   3'h1

// field positions
`define PASB_CTRL_RUN     0
`define PASB_IRQ_BLOCK    0
`define PASB_IRQ_CFGERR   1
`define PASB_IRQ_OVERRUN  2

// reset values
`define PASB_BUFLEN_RST   8'h80
`define PASB_ITERS_RST    16'h000a
`define PASB_PERIOD_RST   24'h000fa0
`define PASB_CHMASK_RST   18'h00000

// channel map: 16 regular inputs, then the two internal sensors
`define PASB_NCH          18
`define PASB_MASK_TEMP    18'h10000
`define PASB_MASK_VOLT    18'h20000

// bus answers
`define PASB_RESP_OKAY    2'h0
`define PASB_RESP_SLVERR  2'h2

`endif

// ---- rtl/pasb_pkg.sv ----
// types shared by the periodic sample buffer modules
// assumes: nothing beyond a SystemVerilog compiler
package pasb_pkg;
  typedef logic [15:0] pasb_word_t;
  typedef logic [6:0]  pasb_ptr_t;
  typedef logic [7:0]  pasb_len_t;
  typedef logic [4:0]  pasb_ch_t;
  // scan sequencer: gray along idle, wait, transfer
  typedef enum logic [1:0] {PASB_SEQ_IDLE = 2'h0, PASB_SEQ_WAIT = 2'h1, PASB_SEQ_XFER = 2'h3} pasb_seq_t;
  // transfer engine
  typedef enum logic [1:0] {PASB_ENG_IDLE = 2'h0, PASB_ENG_PULL = 2'h1} pasb_eng_t;
endpackage

// ---- rtl/pasb_xfer_if.sv ----
// link between the sequencer top and its transfer engine
// assumes: both ends run on the one system clock
`timescale 1ns/10ps
interface pasb_xfer_if;
  import pasb_pkg::*;
  logic       run_start;
  logic       scan_done;
  logic       sd_mode;
  logic       sd_valid;
  pasb_word_t sd_data;
  pasb_word_t res_data;
  pasb_ch_t   first_ch;
  pasb_ch_t   last_ch;
  pasb_len_t  buflen;
  logic [15:0] iters;
  pasb_ch_t   res_ch;
  logic       busy;
  logic       wr_en;
  pasb_ptr_t  wr_addr;
  pasb_word_t wr_data;
  logic       notify;
  pasb_ptr_t  notify_idx;

  modport eng (input run_start, scan_done, sd_mode, sd_valid, sd_data, res_data, first_ch, last_ch,
               buflen, iters, output res_ch, busy, wr_en, wr_addr, wr_data, notify, notify_idx);
  modport ctl (output run_start, scan_done, sd_mode, sd_valid, sd_data, res_data, first_ch, last_ch,
               buflen, iters, input res_ch, busy, wr_en, wr_addr, wr_data, notify, notify_idx);
endinterface

// ---- rtl/pasb_xfer.sv ----
// transfer engine: moves each finished scan into the circular buffer and
// counts iterations towards a block notification
// assumes: converter result for res_ch is valid in the same cycle
`timescale 1ns/10ps
`include "pasb_params.svh"
module pasb_xfer (
  input wire logic clk,
  input wire logic resetn,
  pasb_xfer_if.eng x
);
  import pasb_pkg::*;

  pasb_eng_t  state, next_state;
  pasb_ch_t   ch, next_ch;
  pasb_ptr_t  ptr, next_ptr;
  pasb_ptr_t  blk, next_blk;
  pasb_ptr_t  wr_addr, next_wr_addr;
  pasb_ptr_t  idx, next_idx;
  pasb_word_t wr_data, next_wr_data;
  logic [15:0] iter, next_iter;
  logic       wr_en, next_wr_en;
  logic       notify, next_notify;

  // wrap after the last configured location
  function automatic pasb_ptr_t ptr_inc(input pasb_ptr_t p, input pasb_len_t len);
    if ({1'b0, p} + 8'h01 >= len)
      return 7'h00;
    return 7'(p + 7'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state: pull or push, then close the scan
  always_comb begin
    logic end_scan;
    end_scan     = 1'b0;
    next_state   = state;
    next_ch      = ch;
    next_ptr     = ptr;
    next_blk     = blk;
    next_iter    = iter;
    next_idx     = idx;
    next_wr_en   = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_notify  = 1'b0;
    if (x.run_start) begin
      next_state = PASB_ENG_IDLE;
      next_ptr   = 7'h00;
      next_blk   = 7'h00;
      next_iter  = 16'h0000;
    end else begin
      case (state)
        PASB_ENG_IDLE: begin
          if (x.sd_mode) begin
            // results are pushed by the converter, no pull path used
            if (x.sd_valid) begin
              next_wr_en   = 1'b1;
              next_wr_addr = ptr;
              next_wr_data = x.sd_data;
              next_ptr     = ptr_inc(ptr, x.buflen);
            end
            end_scan = x.scan_done;
          end else if (x.scan_done) begin
            next_state = PASB_ENG_PULL;
            next_ch    = x.first_ch;
          end
        end
        PASB_ENG_PULL: begin
          // one channel per cycle, lowest to highest, gaps included
          next_wr_en   = 1'b1;
          next_wr_addr = ptr;
          next_wr_data = x.res_data;
          next_ptr     = ptr_inc(ptr, x.buflen);
          if (ch == x.last_ch) begin
            next_state = PASB_ENG_IDLE;
            end_scan   = 1'b1;
          end else begin
            next_ch = 5'(ch + 5'h01);
          end
        end
        default: next_state = PASB_ENG_IDLE;
      endcase
      // sampling carries on after a block; old locations get overwritten
      if (end_scan) begin
        if ({1'b0, iter} + 17'h00001 >= {1'b0, x.iters}) begin
          next_notify = 1'b1;
          next_idx    = blk;
          next_blk    = next_ptr;
          next_iter   = 16'h0000;
        end else begin
          next_iter = 16'(iter + 16'h0001);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= PASB_ENG_IDLE;
      ch      <= 5'h00;
      ptr     <= 7'h00;
      blk     <= 7'h00;
      iter    <= 16'h0000;
      idx     <= 7'h00;
      wr_en   <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 16'h0000;
      notify  <= 1'b0;
    end else begin
      state   <= next_state;
      ch      <= next_ch;
      ptr     <= next_ptr;
      blk     <= next_blk;
      iter    <= next_iter;
      idx     <= next_idx;
      wr_en   <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      notify  <= next_notify;
    end
  end

  assign x.res_ch     = ch;
  assign x.busy       = (state == PASB_ENG_PULL);
  assign x.wr_en      = wr_en;
  assign x.wr_addr    = wr_addr;
  assign x.wr_data    = wr_data;
  assign x.notify     = notify;
  assign x.notify_idx = idx;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_pull_go;
    x.scan_done && state == PASB_ENG_IDLE && !x.sd_mode && !x.run_start;
  endsequence

  a_pull_start: assert property (s_pull_go |=> state == PASB_ENG_PULL && ch == $past(x.first_ch))
    else $error("pull did not start at the first channel");
  a_pull_order: assert property (state == PASB_ENG_PULL && ch != x.last_ch && !x.run_start
                                 |=> ch == 5'($past(ch) + 5'h01))
    else $error("channel order broken");
  a_pull_store: assert property (state == PASB_ENG_PULL && !x.run_start
                                 |=> wr_en && wr_data == $past(x.res_data))
    else $error("scan result not written");
  a_ptr_wrap: assert property (wr_en ##1 wr_en |-> wr_addr == ptr_inc($past(wr_addr), $past(x.buflen)))
    else $error("buffer pointer step wrong");
  a_sd_no_pull: assert property (x.sd_mode && state == PASB_ENG_IDLE |=> state == PASB_ENG_IDLE)
    else $error("pull path used with sigma-delta converter");
  a_block_count: assert property (notify |-> iter == 16'h0000 && {1'b0, $past(iter)} + 17'h00001 >= {1'b0, $past(x.iters)})
    else $error("notification at wrong iteration");
  a_block_index: assert property (notify |-> idx == $past(blk))
    else $error("notification index wrong");
endmodule

// ---- rtl/pasb_top.sv ----
// periodic sample buffer: timer-driven single scans, results stored in a
// circular buffer of 16-bit words, block notification by interrupt
// assumes: converter logic on the same clock; sigma-delta strap comes from a pin
//
// Notes on behaviour
// - each scan stored in channel order, consecutively
// - notify after configured iterations are stored
// - keep sampling after notify, buffer circular
// - notification carries start index of block
// - single scan only, no group or DMA
// - sigma-delta converter bypasses the pull path
// - each location holds one 16-bit word
// - buffer length configurable, default 128
// - iterations per notify configurable, default 10
// - timer fires one scan, engine stores it
// - gap channels inside range also stored
`timescale 1ns/10ps
`include "pasb_params.svh"
module pasb_top (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    scan_start,
  output pasb_pkg::pasb_ch_t      scan_first_ch,
  output pasb_pkg::pasb_ch_t      scan_last_ch,
  input  wire logic               scan_done,
  output pasb_pkg::pasb_ch_t      res_ch,
  input  wire pasb_pkg::pasb_word_t res_data,
  input  wire logic               res_push_valid,
  input  wire pasb_pkg::pasb_word_t res_push_data,
  input  wire logic               conv_sigma_delta,
  output logic                    irq
);
  import pasb_pkg::*;

  pasb_xfer_if x ();

  pasb_xfer u_xfer (
    .clk    (clk),
    .resetn (resetn),
    .x      (x.eng)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic        aw_rdy, next_aw_rdy;
  logic        w_rdy, next_w_rdy;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        ar_rdy, next_ar_rdy;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic        run, next_run;
  logic        run_start, next_run_start;
  logic [17:0] chmask, next_chmask;
  logic [23:0] period, next_period;
  pasb_len_t   buflen, next_buflen;
  logic [15:0] iters, next_iters;
  pasb_ptr_t   idx, next_idx;
  logic [2:0]  irq_stat, next_irq_stat;
  logic [2:0]  irq_mask, next_irq_mask;
  logic        irq_q, next_irq;
  pasb_ch_t    first_ch, next_first_ch;
  pasb_ch_t    last_ch, next_last_ch;
  pasb_seq_t   seq, next_seq;
  logic [23:0] tcnt, next_tcnt;
  logic        start_q, next_start;
  logic        tick;
  logic        overrun;
  logic        sd_meta;
  logic        sd_sync;
  pasb_word_t  mem [128];

  // byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b])
        old[8*b +: 8] = nw[8*b +: 8];
    return old;
  endfunction

  // lowest (hi=0) or highest (hi=1) selected channel
  function automatic pasb_ch_t ch_edge(input logic [17:0] m, input logic hi);
    pasb_ch_t r;
    r = 5'h00;
    for (int i = 0; i < `PASB_NCH; i++)
      if (m[hi ? i : `PASB_NCH - 1 - i])
        r = 5'(hi ? i : `PASB_NCH - 1 - i);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strap from a pin: two flops before anyone looks at it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sd_meta <= 1'b0;
      sd_sync <= 1'b0;
    end else begin
      sd_meta <= conv_sigma_delta;
      sd_sync <= sd_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, register writes and interrupt status
  always_comb begin
    logic       do_wr;
    logic       bad_cfg;
    logic       cfg_evt;
    logic [2:0] clr;
    do_wr          = !aw_rdy && !w_rdy && !bvalid;
    bad_cfg        = (chmask == 18'h00000) ||
                     ((chmask & (`PASB_MASK_TEMP | `PASB_MASK_VOLT)) != 18'h00000 &&
                      chmask != `PASB_MASK_TEMP && chmask != `PASB_MASK_VOLT);
    cfg_evt        = 1'b0;
    clr            = 3'h0;
    next_aw_rdy    = aw_rdy;
    next_w_rdy     = w_rdy;
    next_aw_addr   = aw_addr;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_ar_rdy    = ar_rdy;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_run       = run;
    next_run_start = 1'b0;
    next_chmask    = chmask;
    next_period    = period;
    next_buflen    = buflen;
    next_iters     = iters;
    next_first_ch  = first_ch;
    next_last_ch   = last_ch;
    next_irq_mask  = irq_mask;
    // address and data may come in either order
    if (s_axi_awvalid && aw_rdy) begin
      next_aw_rdy  = 1'b0;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && w_rdy) begin
      next_w_rdy  = 1'b0;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_aw_rdy = 1'b1;
      next_w_rdy  = 1'b1;
    end
    if (do_wr) begin
      next_bvalid = 1'b1;
      next_bresp  = `PASB_RESP_OKAY;
      case (aw_addr)
        `PASB_OFF_CTRL: begin
          if (w_strb[0] && w_data[`PASB_CTRL_RUN] && !run) begin
            // a bad channel selection refuses the start
            if (bad_cfg) begin
              cfg_evt = 1'b1;
            end else begin
              next_run       = 1'b1;
              next_run_start = 1'b1;
              next_first_ch  = ch_edge(chmask, 1'b0);
              next_last_ch   = ch_edge(chmask, 1'b1);
            end
          end else if (w_strb[0] && !w_data[`PASB_CTRL_RUN]) begin
            next_run = 1'b0;
          end
        end
        `PASB_OFF_CHMASK:  next_chmask   = 18'(wmerge({14'h0000, chmask}, w_data, w_strb));
        `PASB_OFF_PERIOD:  next_period   = 24'(wmerge({8'h00, period}, w_data, w_strb));
        `PASB_OFF_BUFLEN:  next_buflen   = 8'(wmerge({24'h000000, buflen}, w_data, w_strb));
        `PASB_OFF_ITERS:   next_iters    = 16'(wmerge({16'h0000, iters}, w_data, w_strb));
        `PASB_OFF_IRQSTAT: clr           = w_strb[0] ? w_data[2:0] : 3'h0;
        `PASB_OFF_IRQMASK: next_irq_mask = w_strb[0] ? w_data[2:0] : irq_mask;
        default:           next_bresp    = `PASB_RESP_SLVERR;
      endcase
    end
    // read answer one cycle after the address is taken
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_ar_rdy = 1'b1;
    end
    if (s_axi_arvalid && ar_rdy) begin
      next_ar_rdy = 1'b0;
      next_rvalid = 1'b1;
      next_rresp  = `PASB_RESP_OKAY;
      case (s_axi_araddr)
        `PASB_OFF_CTRL:    next_rdata = {31'h00000000, run};
        `PASB_OFF_STATUS:  next_rdata = {29'h00000000, sd_sync, seq != PASB_SEQ_IDLE, run};
        `PASB_OFF_CHMASK:  next_rdata = {14'h0000, chmask};
        `PASB_OFF_PERIOD:  next_rdata = {8'h00, period};
        `PASB_OFF_BUFLEN:  next_rdata = {24'h000000, buflen};
        `PASB_OFF_ITERS:   next_rdata = {16'h0000, iters};
        `PASB_OFF_INDEX:   next_rdata = {25'h0000000, idx};
        `PASB_OFF_IRQSTAT: next_rdata = {29'h00000000, irq_stat};
        `PASB_OFF_IRQMASK: next_rdata = {29'h00000000, irq_mask};
        default: begin
          if (s_axi_araddr[11:9] == `PASB_BUF_REGION) begin
            next_rdata = {16'h0000, mem[s_axi_araddr[8:2]]};
          end else begin
            next_rdata = 32'h00000000;
            next_rresp = `PASB_RESP_SLVERR;
          end
        end
      endcase
    end
    // latest block index for software
    next_idx = x.notify ? x.notify_idx : idx;
    // set wins over a clear in the same cycle
    next_irq_stat = (irq_stat & ~clr) | {overrun, cfg_evt, x.notify};
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // period timer and single-shot scan sequencer
  always_comb begin
    next_seq   = seq;
    next_tcnt  = tcnt;
    next_start = 1'b0;
    tick       = 1'b0;
    if (!run) begin
      next_tcnt = 24'h000000;
    end else if (tcnt + 24'h000001 >= period) begin
      tick      = 1'b1;
      next_tcnt = 24'h000000;
    end else begin
      next_tcnt = 24'(tcnt + 24'h000001);
    end
    // a tick while a scan is still in flight is dropped, not queued
    overrun = tick && seq != PASB_SEQ_IDLE;
    case (seq)
      PASB_SEQ_IDLE: begin
        if (tick) begin
          next_start = 1'b1;
          next_seq   = PASB_SEQ_WAIT;
        end
      end
      PASB_SEQ_WAIT: begin
        if (scan_done)
          next_seq = sd_sync ? PASB_SEQ_IDLE : PASB_SEQ_XFER;
      end
      PASB_SEQ_XFER: begin
        if (!x.busy)
          next_seq = PASB_SEQ_IDLE;
      end
      default: next_seq = PASB_SEQ_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_rdy    <= 1'b1;
      w_rdy     <= 1'b1;
      aw_addr   <= 12'h000;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `PASB_RESP_OKAY;
      ar_rdy    <= 1'b1;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= `PASB_RESP_OKAY;
      run       <= 1'b0;
      run_start <= 1'b0;
      chmask    <= `PASB_CHMASK_RST;
      period    <= `PASB_PERIOD_RST;
      buflen    <= `PASB_BUFLEN_RST;
      iters     <= `PASB_ITERS_RST;
      idx       <= 7'h00;
      irq_stat  <= 3'h0;
      irq_mask  <= 3'h0;
      irq_q     <= 1'b0;
      first_ch  <= 5'h00;
      last_ch   <= 5'h00;
      seq       <= PASB_SEQ_IDLE;
      tcnt      <= 24'h000000;
      start_q   <= 1'b0;
    end else begin
      aw_rdy    <= next_aw_rdy;
      w_rdy     <= next_w_rdy;
      aw_addr   <= next_aw_addr;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      ar_rdy    <= next_ar_rdy;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      run       <= next_run;
      run_start <= next_run_start;
      chmask    <= next_chmask;
      period    <= next_period;
      buflen    <= next_buflen;
      iters     <= next_iters;
      idx       <= next_idx;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      irq_q     <= next_irq;
      first_ch  <= next_first_ch;
      last_ch   <= next_last_ch;
      seq       <= next_seq;
      tcnt      <= next_tcnt;
      start_q   <= next_start;
    end
  end

  // sample storage: no reset, contents undefined until first written
  always_ff @(posedge clk) begin
    if (x.wr_en)
      mem[x.wr_addr] <= x.wr_data;
  end

  // engine hookup
  assign x.run_start = run_start;
  assign x.scan_done = scan_done && seq == PASB_SEQ_WAIT;
  assign x.sd_mode   = sd_sync;
  assign x.sd_valid  = res_push_valid;
  assign x.sd_data   = res_push_data;
  assign x.res_data  = res_data;
  assign x.first_ch  = first_ch;
  assign x.last_ch   = last_ch;
  assign x.buflen    = buflen;
  assign x.iters     = iters;

  assign s_axi_awready = aw_rdy;
  assign s_axi_wready  = w_rdy;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign scan_start    = start_q;
  assign scan_first_ch = first_ch;
  assign scan_last_ch  = last_ch;
  assign res_ch        = x.res_ch;
  assign irq           = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_scan_single: assert property (scan_start |-> seq == PASB_SEQ_WAIT ##1 !scan_start)
    else $error("scan trigger not single shot");
  a_buf_store: assert property (x.wr_en |=> mem[$past(x.wr_addr)] == $past(x.wr_data))
    else $error("sample word not stored");
  a_len_default: assert property ($rose(resetn) |-> buflen == `PASB_BUFLEN_RST)
    else $error("buffer length reset value wrong");
  a_iter_default: assert property ($rose(resetn) |-> iters == `PASB_ITERS_RST)
    else $error("iteration count reset value wrong");
  a_tick_scan: assert property (run && seq == PASB_SEQ_IDLE && tick |=> scan_start)
    else $error("timer tick did not fire a scan");
endmodule

// ---- tb/pasb_conv_model.sv ----
// converter stand-in: answers each scan_start with one scan_done
// assumes: same clock as the sampler, results read combinationally
`timescale 1ns/10ps
module pasb_conv_model (
  input  wire logic               clk,
  input  wire logic               scan_start,
  input  wire pasb_pkg::pasb_ch_t res_ch,
  input  wire logic               sd_mode,
  output logic                    scan_done,
  output pasb_pkg::pasb_word_t    res_data,
  output logic                    push_valid,
  output pasb_pkg::pasb_word_t    push_data
);
  logic [2:0] cnt = 3'h0;
  // channel number in the low bits, so the stored order is visible
  assign res_data = {11'h528, res_ch};
  // sigma-delta: one pushed word per scan, together with its end
  assign push_valid = sd_mode && scan_done;
  assign push_data  = 16'h5a5a;
  // fixed conversion time, kept below the timer period; an unknown start before reset leaves cnt idle
  always @(posedge clk) begin
    scan_done <= (cnt == 3'h1);
    if (scan_start)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= 3'(cnt - 3'h1);
  end
endmodule

// ---- tb/periodic_adc_sample_buffer_tb.sv ----
// bench: lite bus tasks drive the sampler, converter model on the far side
// assumes: sigma-delta strap low until the last test, which uses the push path
`timescale 1ns/10ps
`include "pasb_params.svh"
module periodic_adc_sample_buffer_tb;
  logic clk = 0, resetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sdm = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] rs;
  logic awr, wr, bv, arr, rv, st, sd, irq, pv;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  pasb_pkg::pasb_ch_t fc, lc, ch;
  pasb_pkg::pasb_word_t res, pd;
  int errors = 0, tests_run = 0, i;
  pasb_top dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .scan_start(st),
    .scan_first_ch(fc), .scan_last_ch(lc), .scan_done(sd), .res_ch(ch), .res_data(res),
    .res_push_valid(pv), .res_push_data(pd), .conv_sigma_delta(sdm), .irq(irq));
  pasb_conv_model conv (.clk(clk), .scan_start(st), .res_ch(ch), .sd_mode(sdm), .scan_done(sd),
    .res_data(res), .push_valid(pv), .push_data(pd));
  initial forever #25 clk = ~clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait; a hang ends the run as a failure
  task automatic tick(input int n);
    if (n >= 3000) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    int n;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv === 1'b1) break;
    end
    tick(n); rs = br;
  endtask
  task automatic rreg(input logic [11:0] a);
    int n;
    ara <= a; arv <= 1; rry <= 1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv === 1'b1) break;
    end
    tick(n); rd = rdat; rs = rr;
  endtask
  task automatic wait_irq();
    int n;
    logic low;
    low = 0;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (irq === 1'b0) low = 1;
      else if (low) break;
    end
    tick(n);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    rreg(`PASB_OFF_BUFLEN); chk("buflen", rd, 32'h80);
    rreg(`PASB_OFF_ITERS); chk("iters", rd, 32'ha);
    rreg(12'h100); chk("unmapped", rs, `PASB_RESP_SLVERR);
    $display("test defaults done");
    // empty mask, then sensor plus regular: both starts refused
    wreg(`PASB_OFF_CTRL, 1); rreg(`PASB_OFF_IRQSTAT); chk("no channel", rd, 32'h2);
    wreg(`PASB_OFF_IRQSTAT, 2); wreg(`PASB_OFF_CHMASK, 32'h10001); wreg(`PASB_OFF_CTRL, 1);
    rreg(`PASB_OFF_IRQSTAT); chk("mixed sensor", rd, 32'h2);
    rreg(`PASB_OFF_STATUS); chk("not running", rd[0], 0);
    wreg(`PASB_OFF_IRQSTAT, 2);
    $display("test refusals done");
    // channels 1 and 3: gap channel 2 stored too, two scans per block
    wreg(`PASB_OFF_CHMASK, 32'ha); wreg(`PASB_OFF_BUFLEN, 12); wreg(`PASB_OFF_ITERS, 2);
    wreg(`PASB_OFF_PERIOD, 20); wreg(`PASB_OFF_IRQMASK, 1); wreg(`PASB_OFF_CTRL, 1);
    wait_irq(); rreg(`PASB_OFF_INDEX); chk("index 1", rd, 0);
    chk("first ch", fc, 1); chk("last ch", lc, 3);
    for (i = 0; i < 6; i++) begin
      rreg(12'h200 + 12'(4 * i)); chk("sample", rd, 32'ha501 + (i % 3));
    end
    wreg(`PASB_OFF_IRQSTAT, 1);
    wait_irq(); rreg(`PASB_OFF_INDEX); chk("index 2", rd, 6);
    wreg(`PASB_OFF_IRQSTAT, 1);
    wait_irq(); rreg(`PASB_OFF_INDEX); chk("index wrap", rd, 0);
    wreg(12'h200, 0); chk("buffer ro", rs, `PASB_RESP_SLVERR);
    $display("test sampling done");
    // stop, let any scan in flight finish, then switch the strap: one pushed word per scan
    wreg(`PASB_OFF_CTRL, 0); repeat (20) @(posedge clk); sdm <= 1;
    wreg(`PASB_OFF_IRQSTAT, 1); rreg(`PASB_OFF_STATUS); chk("sd strap", rd[2], 1);
    wreg(`PASB_OFF_CTRL, 1); wait_irq(); rreg(`PASB_OFF_INDEX); chk("sd index", rd, 0);
    rreg(12'h204); chk("sd word", rd, 32'h5a5a);
    // location 2 keeps the old pull result: no channel pulled in this mode
    rreg(12'h208); chk("sd no pull", rd, 32'ha503);
    $display("test sigma-delta done");
    print_verdict();
  end
endmodule
